// ===== design/ccr_consts.svh
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CCR_ADDR_CNT_LOW    8'hf9
`define CCR_ADDR_CNT_HIGH   8'hfa
`define CCR_ADDR_CAP0_LOW   8'hfb
`define CCR_ADDR_CAP0_HIGH  8'hfc
`define CCR_ADDR_CAP1_LOW   8'he9
`define CCR_ADDR_CAP1_HIGH  8'hea
`define CCR_ADDR_CAP2_LOW   8'heb
`define CCR_ADDR_CAP2_HIGH  8'hec
`define CCR_ADDR_CAP3_LOW   8'hed
`define CCR_ADDR_CAP3_HIGH  8'hee
`define CCR_ADDR_CAP4_LOW   8'hfd
`define CCR_ADDR_CAP4_HIGH  8'hfe
`define CCR_ADDR_CAP5_LOW   8'hd2
`define CCR_ADDR_CAP5_HIGH  8'hd3

// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define CCR_RESET_BYTE      8'h00
`define CCR_RESET_WORD      16'h0000
`define CCR_NUM_MODULES     6
`define CCR_WDOG_MODULE     3'h5

`endif

// ===== design/ccr_pkg.sv
package ccr_pkg;

  typedef logic [7:0]  ccr_byte_t;
  typedef logic [15:0] ccr_word_t;

  typedef enum logic [1:0] {
    CCR_SEL_NONE,
    CCR_SEL_LOW,
    CCR_SEL_HIGH
  } ccr_half_t;

endpackage : ccr_pkg

// ===== design/ccr_array_counter.sv
`timescale 1ns/10ps
`include "ccr_consts.svh"

// 16-bit free counter with high byte snapshot on low byte read
module ccr_array_counter (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic             count_en,
  input  wire logic             wr_low,
  input  wire logic             wr_high,
  input  wire logic             rd_low,
  input  wire logic [7:0]       wr_data,
  output      ccr_pkg::ccr_word_t count,
  output      ccr_pkg::ccr_byte_t snap_high
);

  ccr_pkg::ccr_word_t cnt_ff;
  ccr_pkg::ccr_word_t nxt_cnt;
  ccr_pkg::ccr_byte_t snap_ff;
  ccr_pkg::ccr_byte_t nxt_snap;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_snap = snap_ff;
    if (wr_low) begin
      nxt_cnt[7:0] = wr_data;
    end else if (wr_high) begin
      nxt_cnt[15:8] = wr_data;
    end else if (count_en) begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
    if (rd_low) begin
      nxt_snap = cnt_ff[15:8];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_ff  <= `CCR_RESET_WORD;
      snap_ff <= `CCR_RESET_BYTE;
    end else if (clk_en) begin
      cnt_ff  <= nxt_cnt;
      snap_ff <= nxt_snap;
    end
  end

  assign count     = cnt_ff;
  assign snap_high = snap_ff;

endmodule : ccr_array_counter

// ===== design/ccr_capture_module.sv
`timescale 1ns/10ps
`include "ccr_consts.svh"

// one capture/compare channel with its auto-reload value
module ccr_capture_module (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic             wr_low,
  input  wire logic             wr_high,
  input  wire logic             reload_sel,
  input  wire logic [7:0]       wr_data,
  input  wire logic [15:0]      count,
  output      ccr_pkg::ccr_word_t value,
  output      ccr_pkg::ccr_word_t reload,
  output      logic             cmp_en,
  output      logic             match
);

  ccr_pkg::ccr_word_t val_ff;
  ccr_pkg::ccr_word_t nxt_val;
  ccr_pkg::ccr_word_t rld_ff;
  ccr_pkg::ccr_word_t nxt_rld;
  logic               cmp_en_ff;
  logic               nxt_cmp_en;
  logic               match_ff;
  logic               nxt_match;

  always_comb begin
    nxt_val    = val_ff;
    nxt_rld    = rld_ff;
    nxt_cmp_en = cmp_en_ff;
    if (wr_low) begin
      if (reload_sel) begin
        nxt_rld[7:0] = wr_data;
      end else begin
        nxt_val[7:0] = wr_data;
      end
      nxt_cmp_en = 1'b0;
    end
    if (wr_high) begin
      if (reload_sel) begin
        nxt_rld[15:8] = wr_data;
      end else begin
        nxt_val[15:8] = wr_data;
      end
      nxt_cmp_en = 1'b1;
    end
    nxt_match = cmp_en_ff && (count == val_ff);
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      val_ff    <= `CCR_RESET_WORD;
      rld_ff    <= `CCR_RESET_WORD;
      cmp_en_ff <= 1'b0;
      match_ff  <= 1'b0;
    end else if (clk_en) begin
      val_ff    <= nxt_val;
      rld_ff    <= nxt_rld;
      cmp_en_ff <= nxt_cmp_en;
      match_ff  <= nxt_match;
    end
  end

  assign value  = val_ff;
  assign reload = rld_ff;
  assign cmp_en = cmp_en_ff;
  assign match  = match_ff;

endmodule : ccr_capture_module

// ===== design/ccr_regs.sv
// Behaviour
// - 16-bit counter as two zero-reset bytes
// - high read returns snapshot taken at low read
// - counter writes ignored while watchdog enabled
// - six 16-bit capture values, two bytes each
// - low address reaches reload low by select
// - high address reaches reload high by select
// - low byte write clears comparator enable
// - high byte write sets comparator enable
// - comparator enable gates counter-versus-value match
// - watchdog enable locks module five mode
`timescale 1ns/10ps
`include "ccr_consts.svh"

module ccr_regs (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        watchdog_enable,
  input  wire logic        auto_reload_select,
  input  wire logic        count_en,
  output logic      [7:0]  sfr_rdata,
  output logic      [5:0]  comparator_function_enable,
  output logic      [5:0]  compare_match,
  output logic             mod5_mode_lock
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic [7:0] cap_addr(input logic [2:0] idx, input logic high);
    logic [7:0] a;
    a = 8'h00;
    case (idx)
      3'h0:    a = high ? `CCR_ADDR_CAP0_HIGH : `CCR_ADDR_CAP0_LOW;
      3'h1:    a = high ? `CCR_ADDR_CAP1_HIGH : `CCR_ADDR_CAP1_LOW;
      3'h2:    a = high ? `CCR_ADDR_CAP2_HIGH : `CCR_ADDR_CAP2_LOW;
      3'h3:    a = high ? `CCR_ADDR_CAP3_HIGH : `CCR_ADDR_CAP3_LOW;
      3'h4:    a = high ? `CCR_ADDR_CAP4_HIGH : `CCR_ADDR_CAP4_LOW;
      3'h5:    a = high ? `CCR_ADDR_CAP5_HIGH : `CCR_ADDR_CAP5_LOW;
      default: a = 8'h00;
    endcase
    return a;
  endfunction : cap_addr

  logic               cnt_wr_low;
  logic               cnt_wr_high;
  logic               cnt_rd_low;
  ccr_pkg::ccr_word_t count;
  ccr_pkg::ccr_byte_t snap_high;
  ccr_pkg::ccr_word_t cap_value  [0:5];
  ccr_pkg::ccr_word_t cap_reload [0:5];
  logic [5:0]         cap_wr_low;
  logic [5:0]         cap_wr_high;
  logic [5:0]         cap_cmp_en;
  logic [5:0]         cap_match;

  assign cnt_wr_low  = sfr_wr && !watchdog_enable && (sfr_addr == `CCR_ADDR_CNT_LOW);
  assign cnt_wr_high = sfr_wr && !watchdog_enable && (sfr_addr == `CCR_ADDR_CNT_HIGH);
  assign cnt_rd_low  = sfr_rd && (sfr_addr == `CCR_ADDR_CNT_LOW);

  // ----------------------------------------
  // counter and channels
  // ----------------------------------------
  ccr_array_counter u_counter (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .count_en  (count_en),
    .wr_low    (cnt_wr_low),
    .wr_high   (cnt_wr_high),
    .rd_low    (cnt_rd_low),
    .wr_data   (sfr_wdata),
    .count     (count),
    .snap_high (snap_high)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `CCR_NUM_MODULES; gi = gi + 1) begin : g_cap
      assign cap_wr_low[gi]  = sfr_wr && (sfr_addr == cap_addr(3'(gi), 1'b0));
      assign cap_wr_high[gi] = sfr_wr && (sfr_addr == cap_addr(3'(gi), 1'b1));
      ccr_capture_module u_cap (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .clk_en     (clk_en),
        .wr_low     (cap_wr_low[gi]),
        .wr_high    (cap_wr_high[gi]),
        .reload_sel (auto_reload_select),
        .wr_data    (sfr_wdata),
        .count      (count),
        .value      (cap_value[gi]),
        .reload     (cap_reload[gi]),
        .cmp_en     (cap_cmp_en[gi]),
        .match      (cap_match[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // read data and status outputs
  // ----------------------------------------
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [5:0] cmp_en_ff;
  logic [5:0] match_ff;
  logic       lock_ff;

  always_comb begin
    nxt_rdata = rdata_ff;
    if (sfr_rd) begin
      nxt_rdata = 8'h00;
      if (sfr_addr == `CCR_ADDR_CNT_LOW) begin
        nxt_rdata = count[7:0];
      end else if (sfr_addr == `CCR_ADDR_CNT_HIGH) begin
        nxt_rdata = snap_high;
      end
      for (int i = 0; i < `CCR_NUM_MODULES; i++) begin
        if (sfr_addr == cap_addr(3'(i), 1'b0)) begin
          nxt_rdata = auto_reload_select ? cap_reload[i][7:0] : cap_value[i][7:0];
        end
        if (sfr_addr == cap_addr(3'(i), 1'b1)) begin
          nxt_rdata = auto_reload_select ? cap_reload[i][15:8] : cap_value[i][15:8];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_ff  <= `CCR_RESET_BYTE;
      cmp_en_ff <= 6'h00;
      match_ff  <= 6'h00;
      lock_ff   <= 1'b0;
    end else if (clk_en) begin
      rdata_ff  <= nxt_rdata;
      cmp_en_ff <= cap_cmp_en;
      match_ff  <= cap_match;
      lock_ff   <= watchdog_enable;
    end
  end

  assign sfr_rdata                  = rdata_ff;
  assign comparator_function_enable = cmp_en_ff;
  assign compare_match              = match_ff;
  assign mod5_mode_lock             = lock_ff;

endmodule : ccr_regs

// ===== sim/ccr_regs_monitor.sv
`timescale 1ns/10ps
module ccr_regs_monitor (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic       watchdog_enable,
  input wire logic       auto_reload_select,
  input wire logic [7:0] sfr_rdata,
  input wire logic [5:0] comparator_function_enable,
  input wire logic [5:0] compare_match,
  input wire logic       mod5_mode_lock
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  lock_follow_a: assert property ($past(resetn) && $past(clk_en) |->
    mod5_mode_lock == $past(watchdog_enable)) else $error("lock not tracking");
  low_clear_a: assert property (clk_en && sfr_wr && sfr_addr == 8'hfb ##1 clk_en
    |=> !comparator_function_enable[0]) else $error("enable not cleared");
  high_set_a: assert property (clk_en && sfr_wr && sfr_addr == 8'hd3 ##1 clk_en
    |=> comparator_function_enable[5]) else $error("enable not set");
  match_gate_a: assert property ((compare_match & ~(comparator_function_enable
    | $past(comparator_function_enable))) == 6'h00) else $error("match while off");
  reset_zero_a: assert property (disable iff (1'b0) !resetn |=>
    sfr_rdata == 8'h00 && comparator_function_enable == 6'h00 && compare_match == 6'h00)
    else $error("not zero after reset");
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved");
  cap_back_a: assert property (clk_en && sfr_wr && sfr_addr == 8'hfb && !auto_reload_select
    ##1 clk_en && !sfr_wr
    ##1 clk_en && sfr_rd && sfr_addr == 8'hfb && !auto_reload_select
    |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("capture byte lost");
  reload_back_a: assert property (clk_en && sfr_wr && sfr_addr == 8'hd3 && auto_reload_select
    ##1 clk_en && !sfr_wr
    ##1 clk_en && sfr_rd && sfr_addr == 8'hd3 && auto_reload_select
    |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("reload byte lost");
endmodule : ccr_regs_monitor

// ===== sim/ccr_regs_test.sv
`timescale 1ns/10ps
module ccr_regs_test;
  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       clk_en = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic       watchdog_enable = 1'b0;
  logic       auto_reload_select = 1'b0;
  logic       count_en = 1'b0;
  logic [7:0] sfr_rdata;
  logic [5:0] comparator_function_enable;
  logic [5:0] compare_match;
  logic       mod5_mode_lock;
  int         err_total = 0;
  int         checks = 0;
  logic [7:0] am [14] = '{8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'he9, 8'hea, 8'heb,
                         8'hec, 8'hed, 8'hee, 8'hfd, 8'hfe, 8'hd2, 8'hd3};
  logic [7:0] m [2][12] = '{default: 8'h00};
  logic [5:0] en = 6'h00;
  logic       hit = 1'b0;

  ccr_regs uut (.*);

  always #10 ref_clk = ~ref_clk;

  // ----------------
  // tasks
  // ----------------
  function automatic int aidx(input int k, input int h);
    return 2 + 2 * k + h;
  endfunction : aidx

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    @(negedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
    @(negedge ref_clk);
  endtask : rd

  task automatic cap(input int k, input int h, input logic s, input logic [7:0] d);
    auto_reload_select = s;
    wr(am[aidx(k, h)], d);
    m[s][aidx(k, h) - 2] = d;
    en[k] = h[0];
    rd(am[aidx(k, h)], d);
    @(negedge ref_clk);
    chk({2'h0, comparator_function_enable}, {2'h0, en});
  endtask : cap

  task final_report;
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    #100000;
    err_total++;
    final_report();
  end

  initial begin
    void'($urandom(85));
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    for (int i = 0; i < 14; i++) rd(am[i], 8'h00);
    cap(0, 0, 1'b0, 8'h5a);
    cap(5, 1, 1'b1, 8'ha5);
    for (int i = 0; i < 40; i++) cap($urandom % 6, $urandom % 2, 1'($urandom), 8'($urandom));
    for (int j = 0; j < 24; j++) begin
      auto_reload_select = j >= 12;
      rd(am[j % 12 + 2], m[j / 12][j % 12]);
    end
    wr(8'hf9, 8'hff);
    wr(8'hfa, 8'h12);
    rd(8'hf9, 8'hff);
    count_en = 1'b1;
    repeat (3) @(negedge ref_clk);
    count_en = 1'b0;
    rd(8'hfa, 8'h12);
    rd(8'hf9, 8'h02);
    rd(8'hfa, 8'h13);
    watchdog_enable = 1'b1;
    wr(8'hf9, 8'($urandom));
    wr(8'hfa, 8'($urandom));
    rd(8'hf9, 8'h02);
    rd(8'hfa, 8'h13);
    chk({7'h00, mod5_mode_lock}, 8'h01);
    watchdog_enable = 1'b0;
    cap(0, 0, 1'b0, 8'h05);
    cap(0, 1, 1'b0, 8'h00);
    wr(8'hf9, 8'h00);
    wr(8'hfa, 8'h00);
    count_en = 1'b1;
    repeat (12) begin
      @(negedge ref_clk);
      hit = hit | compare_match[0];
    end
    count_en = 1'b0;
    chk({7'h00, hit}, 8'h01);
    // ----------------
    // clock enable low freezes counter, values and enables
    // ----------------
    clk_en = 1'b0;
    count_en = 1'b1;
    wr(8'hfb, 8'h77);
    clk_en = 1'b1;
    count_en = 1'b0;
    rd(8'hfb, 8'h05);
    rd(8'hf9, 8'h0c);
    chk({2'h0, comparator_function_enable}, {2'h0, en});
    // ----------------
    // reset in mid run clears everything again
    // ----------------
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    for (int i = 0; i < 14; i++) rd(am[i], 8'h00);
    chk({2'h0, comparator_function_enable}, 8'h00);
    rd(8'h00, 8'h00);
    final_report();
  end
endmodule : ccr_regs_test

bind ccr_regs ccr_regs_monitor mon (.*);
